// ### verilog/ccr_pkg.sv
// ccr_pkg: shared constants and types of the core clock and reset release block
package ccr_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] CCR_OFS_PWR_CTL = 12'h000;
    localparam logic [11:0] CCR_OFS_STATUS = 12'h004;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CCR_MULT_W = 7;
    localparam int CCR_MULT_LSB = 0;
    localparam int CCR_DIV_LSB = 8;
    localparam int CCR_HALVE_BIT = 10;
    localparam int CCR_ST_RELEASED_BIT = 0;
    localparam int CCR_ST_STRAP_LSB = 1;

    // ------------------------------------------------------------
    // divider codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] CCR_DIV_2 = 2'h0;
    localparam logic [1:0] CCR_DIV_4 = 2'h1;
    localparam logic [1:0] CCR_DIV_8 = 2'h2;
    localparam logic [1:0] CCR_DIV_16 = 2'h3;
    localparam logic [4:0] CCR_DIV_VAL_2 = 5'h02;
    localparam logic [4:0] CCR_DIV_VAL_4 = 5'h04;
    localparam logic [4:0] CCR_DIV_VAL_8 = 5'h08;
    localparam logic [4:0] CCR_DIV_VAL_16 = 5'h10;
    // multiplier loaded for each strap code; plain defaults
    localparam logic [6:0] CCR_STRAP_MULT_0 = 7'h08;
    localparam logic [6:0] CCR_STRAP_MULT_1 = 7'h20;
    localparam logic [6:0] CCR_STRAP_MULT_2 = 7'h10;
    localparam logic [6:0] CCR_STRAP_MULT_3 = 7'h08;
    localparam logic [1:0] CCR_STRAP_RST = 2'h0;

    // ------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------
    localparam int CCR_RELEASE_REF_CYCLES = 4096;
    localparam int CCR_RELEASE_CORE_CYCLES = 2;
    localparam int CCR_CNT_W = 13;

    typedef struct packed {
        logic input_halving_enable;
        logic [1:0] loop_post_divider;
        logic [CCR_MULT_W-1:0] loop_multiplier;
    } ccr_pwr_ctl_s;

    typedef enum logic [1:0] {
        CCR_HELD,
        CCR_COUNT_REF,
        CCR_COUNT_CORE,
        CCR_RUN
    } ccr_state_e;

endpackage : ccr_pkg

// ### verilog/ccr_sync.sv
// ccr_sync: two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module ccr_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule : ccr_sync

// ### verilog/ccr_top.sv
// ccr_top: loop ratio control, peripheral clock and core reset release timing
//
// Contract
// - reset-time ratio taken from clock ratio straps
// - multiplier loaded from straps, then software-programmable
// - post-divider selectable 2, 4, 8, 16
// - post-divider forced to 2 during reset
// - oscillator 2xMxFin, core = oscillator/divider
// - input halving feeds loop with reference/2
// - peripheral clock period is two core periods
// - core reset held 4096 reference plus 2 core
// - missed setup may add one reference cycle
`timescale 1ns/1ps
module ccr_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // device pins
    input wire logic ext_reset_n,
    input wire logic reference_clock_in,
    input wire logic [1:0] clock_ratio_strap_pins,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // loop settings and ratio
    output ccr_pkg::ccr_pwr_ctl_s loop_settings,
    output logic [7:0] vco_ratio,
    output logic [5:0] core_ratio_den,
    // clocks and resets out
    output logic peripheral_clock,
    output logic core_reset_n
);
    import ccr_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    logic [3:0] pins_sync;
    logic ext_rst_s;
    logic ref_s;
    logic [1:0] strap_s;

    ccr_sync #(.WIDTH(4)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in({clock_ratio_strap_pins, reference_clock_in, ext_reset_n}),
        .sync_out(pins_sync)
    );

    assign ext_rst_s = pins_sync[0];
    assign ref_s = pins_sync[1];
    assign strap_s = pins_sync[3:2];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ccr_pwr_ctl_s pwr_ctl;
    ccr_pwr_ctl_s next_pwr_ctl;
    logic [1:0] strap;
    logic [1:0] next_strap;
    ccr_state_e state;
    ccr_state_e next_state;
    logic [CCR_CNT_W-1:0] cnt;
    logic [CCR_CNT_W-1:0] next_cnt;
    logic ref_d;
    logic ref_rise;
    logic [31:0] next_prdata;
    logic next_peripheral_clock;
    logic next_core_reset_n;
    logic [7:0] next_vco_ratio;
    logic [5:0] next_core_ratio_den;
    logic [4:0] div_val;
    logic [6:0] strap_mult;
    logic wr_en;
    logic addr_ok;

    assign ref_rise = ref_s && !ref_d;
    assign addr_ok = (paddr == CCR_OFS_PWR_CTL) || (paddr == CCR_OFS_STATUS);
    assign wr_en = psel && penable && pwrite && (paddr == CCR_OFS_PWR_CTL);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // ------------------------------------------------------------
    // strap decode and divider decode
    // ------------------------------------------------------------
    always_comb begin
        case (strap_s)
            2'h0: strap_mult = CCR_STRAP_MULT_0;
            2'h1: strap_mult = CCR_STRAP_MULT_1;
            2'h2: strap_mult = CCR_STRAP_MULT_2;
            default: strap_mult = CCR_STRAP_MULT_3;
        endcase
        case (pwr_ctl.loop_post_divider)
            CCR_DIV_2: div_val = CCR_DIV_VAL_2;
            CCR_DIV_4: div_val = CCR_DIV_VAL_4;
            CCR_DIV_8: div_val = CCR_DIV_VAL_8;
            default: div_val = CCR_DIV_VAL_16;
        endcase
    end

    // ------------------------------------------------------------
    // control register and straps
    // ------------------------------------------------------------
    always_comb begin
        next_pwr_ctl = pwr_ctl;
        next_strap = strap;
        if (!ext_rst_s) begin
            next_strap = strap_s;
            next_pwr_ctl.loop_multiplier = strap_mult;
            next_pwr_ctl.loop_post_divider = CCR_DIV_2;
            next_pwr_ctl.input_halving_enable = 1'b0;
        end else if (wr_en) begin
            // limits on the chosen values are left to software
            next_pwr_ctl.loop_multiplier = pwdata[CCR_MULT_LSB +: CCR_MULT_W];
            next_pwr_ctl.loop_post_divider = pwdata[CCR_DIV_LSB +: 2];
            next_pwr_ctl.input_halving_enable = pwdata[CCR_HALVE_BIT];
        end
        // core/ref = 2*M / (D * (halving ? 2 : 1))
        next_vco_ratio = {pwr_ctl.loop_multiplier, 1'b0};
        next_core_ratio_den = pwr_ctl.input_halving_enable ? {div_val, 1'b0}
                                                           : {1'b0, div_val};
    end

    // ------------------------------------------------------------
    // core reset release sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_core_reset_n = 1'b0;
        case (state)
            CCR_HELD: begin
                next_cnt = '0;
                if (ext_rst_s) begin
                    next_state = CCR_COUNT_REF;
                end
            end
            CCR_COUNT_REF: begin
                // synchroniser lag may cost one more reference edge
                if (ref_rise) begin
                    next_cnt = cnt + 1'b1;
                end
                if (ref_rise && (cnt == CCR_CNT_W'(CCR_RELEASE_REF_CYCLES - 1))) begin
                    next_state = CCR_COUNT_CORE;
                    next_cnt = '0;
                end
            end
            CCR_COUNT_CORE: begin
                next_cnt = cnt + 1'b1;
                if (cnt == CCR_CNT_W'(CCR_RELEASE_CORE_CYCLES - 1)) begin
                    next_state = CCR_RUN;
                    next_core_reset_n = 1'b1;
                end
            end
            CCR_RUN: begin
                next_core_reset_n = 1'b1;
            end
            default: begin
                next_state = CCR_HELD;
            end
        endcase
        if (!ext_rst_s) begin
            next_state = CCR_HELD;
            next_core_reset_n = 1'b0;
        end
        // divide-by-two of the core clock
        next_peripheral_clock = core_reset_n ? !peripheral_clock : 1'b0;
    end

    // ------------------------------------------------------------
    // apb read data, loaded in the setup cycle
    // ------------------------------------------------------------
    always_comb begin
        next_prdata = prdata;
        if (psel && !penable) begin
            next_prdata = 32'h0000_0000;
            if (paddr == CCR_OFS_PWR_CTL) begin
                next_prdata[CCR_MULT_LSB +: CCR_MULT_W] = pwr_ctl.loop_multiplier;
                next_prdata[CCR_DIV_LSB +: 2] = pwr_ctl.loop_post_divider;
                next_prdata[CCR_HALVE_BIT] = pwr_ctl.input_halving_enable;
            end else if (paddr == CCR_OFS_STATUS) begin
                next_prdata[CCR_ST_RELEASED_BIT] = core_reset_n;
                next_prdata[CCR_ST_STRAP_LSB +: 2] = strap;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_ctl <= '{input_halving_enable: 1'b0, loop_post_divider: CCR_DIV_2,
                       loop_multiplier: CCR_STRAP_MULT_0};
            strap <= CCR_STRAP_RST;
            state <= CCR_HELD;
            cnt <= '0;
            ref_d <= 1'b0;
            prdata <= 32'h0000_0000;
            peripheral_clock <= 1'b0;
            core_reset_n <= 1'b0;
            vco_ratio <= 8'h00;
            core_ratio_den <= 6'h00;
        end else begin
            pwr_ctl <= next_pwr_ctl;
            strap <= next_strap;
            state <= next_state;
            cnt <= next_cnt;
            ref_d <= ref_s;
            prdata <= next_prdata;
            peripheral_clock <= next_peripheral_clock;
            core_reset_n <= next_core_reset_n;
            vco_ratio <= next_vco_ratio;
            core_ratio_den <= next_core_ratio_den;
        end
    end

    assign loop_settings = pwr_ctl;

endmodule : ccr_top

// ### testbench/ccr_board.sv
// ccr_board: board reference clock source and reset pin driver
`timescale 1ns/1ps
module ccr_board (
    // request from the bench
    input wire logic rst_req,
    // device pins
    output logic reference_clock_in,
    output logic ext_reset_n
);
    // free running from time zero, so valid long before any release
    initial begin
        reference_clock_in = 1'b0;
        #7;
        forever #40 reference_clock_in = ~reference_clock_in;
    end
    // the bench holds requests far beyond four reference periods
    assign ext_reset_n = ~rst_req;
endmodule : ccr_board

// ### testbench/ccr_top_asserts.sv
// ccr_top_asserts: port checks of ratio outputs and core reset release
`timescale 1ns/1ps
module ccr_top_chk #(
    parameter int REF_PER = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // pins and bus
    input wire logic ext_reset_n,
    input wire logic [1:0] clock_ratio_strap_pins,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // outputs
    input wire ccr_pkg::ccr_pwr_ctl_s loop_settings,
    input wire logic [7:0] vco_ratio,
    input wire logic [5:0] core_ratio_den,
    input wire logic peripheral_clock,
    input wire logic core_reset_n
);
    import ccr_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // window allows sync latency and one extra reference cycle
    localparam int LO = 4096 * REF_PER - 4;
    localparam int HI = 4097 * REF_PER + 8;
    logic [15:0] high_cnt;
    logic [15:0] next_high_cnt;
    logic [6:0] strap_mult;
    always_comb next_high_cnt = !ext_reset_n ? 16'h0 : high_cnt + {15'h0, high_cnt != 16'hFFFF};
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) high_cnt <= 16'h0;
        else high_cnt <= next_high_cnt;
    end
    always_comb begin
        case (clock_ratio_strap_pins)
            2'h1: strap_mult = CCR_STRAP_MULT_1;
            2'h2: strap_mult = CCR_STRAP_MULT_2;
            2'h3: strap_mult = CCR_STRAP_MULT_3;
            default: strap_mult = CCR_STRAP_MULT_0;
        endcase
    end
    strap_mult_a: assert property (
        !ext_reset_n [*5] |-> loop_settings.loop_multiplier == strap_mult) else $error("mult");
    div_forced_a: assert property (
        !ext_reset_n [*5] |-> loop_settings.loop_post_divider == CCR_DIV_2
        && !loop_settings.input_halving_enable) else $error("div");
    core_held_a: assert property (
        !ext_reset_n [*4] |-> !core_reset_n) else $error("held");
    release_time_a: assert property (
        $rose(core_reset_n) |-> high_cnt >= LO && high_cnt <= HI) else $error("release");
    pclk_toggle_a: assert property (
        core_reset_n [*3] |-> peripheral_clock != $past(peripheral_clock)) else $error("pclk");
    ratio_out_a: assert property (
        core_reset_n && $stable(loop_settings) |->
        vco_ratio == {loop_settings.loop_multiplier, 1'b0} && core_ratio_den ==
        (6'h02 << loop_settings.loop_post_divider) << loop_settings.input_halving_enable)
        else $error("ratio");
    ctl_write_a: assert property (
        psel && penable && pwrite && paddr == CCR_OFS_PWR_CTL && core_reset_n |=>
        loop_settings == ccr_pwr_ctl_s'({$past(pwdata[10:8]), $past(pwdata[6:0])}))
        else $error("write");
    strap_ignore_a: assert property (
        ext_reset_n [*4] ##0 !psel |=> $stable(loop_settings.loop_multiplier))
        else $error("strap");
endmodule : ccr_top_chk

// ### testbench/ccr_top_bench.sv
// ccr_top_bench: self-checking bench of ratio control and core reset release
`timescale 1ns/1ps
module ccr_top_bench;
    import ccr_pkg::*;
    logic core_clk, rst_n, rst_req, ext_reset_n, reference_clock_in, er;
    logic psel, penable, pwrite, pready, pslverr, peripheral_clock, core_reset_n;
    logic [1:0] clock_ratio_strap_pins;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] vco_ratio;
    logic [5:0] core_ratio_den;
    ccr_pwr_ctl_s loop_settings;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    ccr_top dut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ext_reset_n(ext_reset_n),
        .reference_clock_in(reference_clock_in),
        .clock_ratio_strap_pins(clock_ratio_strap_pins),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .loop_settings(loop_settings),
        .vco_ratio(vco_ratio),
        .core_ratio_den(core_ratio_den),
        .peripheral_clock(peripheral_clock),
        .core_reset_n(core_reset_n)
    );
    ccr_board board (.rst_req(rst_req), .reference_clock_in(reference_clock_in),
        .ext_reset_n(ext_reset_n));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic print_verdict;
        if (errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // pin held low well past clock and strap settling
    task automatic boot(input logic [1:0] s, input logic [6:0] m);
        int n;
        logic p;
        n = 0;
        @(posedge core_clk);
        clock_ratio_strap_pins <= s;
        rst_req <= 1'b1;
        repeat (1000) @(posedge core_clk);
        apb(1'b1, CCR_OFS_PWR_CTL, 32'h0000_077F);
        @(negedge core_clk);
        check(loop_settings, {3'h0, m});
        @(posedge core_clk);
        rst_req <= 1'b0;
        while (core_reset_n !== 1'b1) begin
            @(posedge core_clk);
            n++;
        end
        check(n >= 4096 * 4 - 4 && n <= 4097 * 4 + 8, 32'h1);
        @(negedge core_clk);
        p = peripheral_clock;
        @(negedge core_clk);
        check(peripheral_clock ^ p, 32'h1);
        apb(1'b0, CCR_OFS_STATUS, 32'h0);
        check(rd, {29'h0, s, 1'b1});
        check(er, 32'h0);
    endtask : boot
    // small multiplier keeps the oscillator well inside its range
    task automatic ratios;
        logic [31:0] d;
        for (int c = 0; c < 8; c++) begin
            d = {21'h0, c[0], c[2:1], 8'h11};
            apb(1'b1, CCR_OFS_PWR_CTL, d);
            repeat (2) @(negedge core_clk);
            check(vco_ratio, 32'h22);
            check(core_ratio_den, (6'h02 << c[2:1]) << c[0]);
            apb(1'b0, CCR_OFS_PWR_CTL, 32'h0);
            check(rd, d);
        end
    endtask : ratios
    task automatic refused;
        clock_ratio_strap_pins <= 2'h3;
        apb(1'b1, CCR_OFS_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, 12'h008, 32'h0);
        check(er, 32'h1);
        check(rd, 32'h0);
        apb(1'b0, CCR_OFS_STATUS, 32'h0);
        check(rd, 32'h3);
        apb(1'b0, CCR_OFS_PWR_CTL, 32'h0);
        check(rd, 32'h711);
    endtask : refused
    initial begin
        rst_n = 1'b0;
        rst_req = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        clock_ratio_strap_pins = 2'h1;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        boot(2'h1, CCR_STRAP_MULT_1);
        ratios();
        refused();
        boot(2'h2, CCR_STRAP_MULT_2);
        boot(2'h3, CCR_STRAP_MULT_3);
        boot(2'h0, CCR_STRAP_MULT_0);
        print_verdict();
    end
endmodule : ccr_top_bench

bind ccr_top ccr_top_chk chk (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ext_reset_n(ext_reset_n),
    .clock_ratio_strap_pins(clock_ratio_strap_pins),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .loop_settings(loop_settings),
    .vco_ratio(vco_ratio),
    .core_ratio_den(core_ratio_den),
    .peripheral_clock(peripheral_clock),
    .core_reset_n(core_reset_n)
);
